// ==== core/ldseq_pkg.sv ====
// ldseq_pkg: constants and types for the led dimming sequencer
// assumes a single 250 MHz clock and synchronous active-low reset
package ldseq_pkg;
  // ==========================================================
  // clock
  localparam int CLK_MHZ = 250;
  // ==========================================================
  // shortest dimming pulse high time to honour, in ns
  localparam int MIN_ON_NS  = 300;
  localparam int MIN_ON_CYC = (MIN_ON_NS * CLK_MHZ + 999) / 1000;
  // ==========================================================
  // pre-boost interval width and reset value, in cycles
  localparam int           PBD_W       = 12;
  localparam logic [11:0]  PBD_RST     = 12'h000;
  // ==========================================================
  // duty measurement
  localparam int           DUTY_W      = 8;      // reference resolution
  localparam int           PER_W       = 14;     // period counter width
  // slowest input 40 kHz gives 6250 cycles; beyond this the period is called idle
  localparam int           PER_MAX_US  = 25;
  localparam int           PER_MAX_CYC = PER_MAX_US * CLK_MHZ;
  // settling time of the reference filter, in us (about 0.5 ms)
  localparam int           SETTLE_US   = 500;
  localparam int           FILT_SHIFT  = 4;      // iir weight 1/16 per period
  localparam logic [7:0]   REF_FULL    = 8'hFF;
  // ==========================================================
  // sequencer states
  typedef enum logic [3:0] {
    LDSEQ_OFF  = 4'b0001,
    LDSEQ_PRE  = 4'b0010,
    LDSEQ_ON   = 4'b0100,
    LDSEQ_TAIL = 4'b1000
  } ldseq_state_t;
endpackage

// ==== core/ldseq_duty.sv ====
// ldseq_duty: measures duty cycle of the analog dim input, filters it
// assumes the input is already synchronous to ref_clk
`timescale 1ns/1ps
module ldseq_duty
  import ldseq_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  input  wire logic              dim_in,
  output logic [DUTY_W-1:0]      ref_level
);
  logic              prev_r;
  logic [PER_W-1:0]  per_r;
  logic [PER_W-1:0]  high_r;
  logic [DUTY_W-1:0] duty_nxt;
  logic [DUTY_W+FILT_SHIFT-1:0] acc_r;
  logic              rise;
  logic              idle;

  assign rise = dim_in & ~prev_r;
  assign idle = (per_r >= PER_W'(PER_MAX_CYC));

  // ==========================================================
  // period and high-sample counting
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      prev_r <= 1'b0;
      per_r  <= '0;
      high_r <= '0;
    end else begin
      prev_r <= dim_in;
      if (rise) begin
        per_r  <= PER_W'(1);
        high_r <= PER_W'(dim_in);
      end else if (idle) begin
        // sticky idle: counters hold so the filter steps to the rest level every cycle
        per_r  <= per_r;
        high_r <= high_r;
      end else begin
        per_r  <= per_r + PER_W'(1);
        high_r <= high_r + PER_W'(dim_in);
      end
    end
  end

  // inverse duty: 100% minus high fraction; idle low input gives full current
  always_comb begin
    logic [PER_W+DUTY_W-1:0] num;
    logic [PER_W+DUTY_W-1:0] den;
    num = '0;
    den = (PER_W+DUTY_W)'(1);
    if (idle) begin
      duty_nxt = prev_r ? '0 : REF_FULL;
    end else begin
      num      = {high_r, {DUTY_W{1'b0}}} - {{DUTY_W{1'b0}}, high_r};
      // a rise right after reset sees an empty period; never divide by zero
      den      = (per_r == '0) ? (PER_W+DUTY_W)'(1) : (PER_W+DUTY_W)'(per_r);
      duty_nxt = REF_FULL - DUTY_W'(num / den);
    end
  end

  // ==========================================================
  // iir filter; divide kept to period ends, trading area for latency
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      acc_r <= {REF_FULL, {FILT_SHIFT{1'b0}}};
    end else if (rise || idle) begin
      acc_r <= acc_r - (acc_r >> FILT_SHIFT)
               + (DUTY_W+FILT_SHIFT)'(duty_nxt);
    end
  end

  assign ref_level = acc_r[DUTY_W+FILT_SHIFT-1:FILT_SHIFT];

  cov_dim_a: cover property (@(posedge ref_clk) disable iff (!nrst) rise ##1 !idle);
  idle_full_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    idle && !prev_r |-> duty_nxt == REF_FULL)
    else $error("idle low input not full current");
endmodule

// ==== core/ldseq_top.sv ====
// ldseq_top: gates led sinks and boost switching from enable and dimming pulse
// assumes inputs synchronous to ref_clk; pull-down is modelled by treating
// an unknown-free low as zero duty
`timescale 1ns/1ps
module ldseq_top
  import ldseq_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  input  wire logic              enable_in,
  input  wire logic              dim_pulse_in,
  input  wire logic              analog_dim_duty_input,
  input  wire logic [PBD_W-1:0]  pre_boost_delay,
  input  wire logic [3:0]        sink_enable,
  output logic [3:0]             sink_on,
  output logic                   boost_on,
  output logic                   comp_float,
  output logic                   bias_keep,
  output logic [DUTY_W-1:0]      current_set_reference
);
  ldseq_state_t      st_r;
  logic [PBD_W-1:0]  cnt_r;
  logic [PBD_W-1:0]  pbd_r;
  logic              act;
  logic              sink_r;
  logic              boost_r;
  logic [PBD_W-1:0]  pre_age_r;
  logic [PBD_W-1:0]  tail_age_r;

  assign act = enable_in & dim_pulse_in;

  // ==========================================================
  // interval latched when a rise is taken in LDSEQ_OFF so a mid-pulse change cannot skew on-time
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pbd_r <= PBD_RST;
    end else if (st_r == LDSEQ_OFF && act) begin
      pbd_r <= pre_boost_delay;
    end
  end

  // ==========================================================
  // sequencer: pulses can be one cycle wide; a rise is taken in LDSEQ_OFF, one during the tail is dropped unless the pulse is still high when the tail ends
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_r  <= LDSEQ_OFF;
      cnt_r <= '0;
    end else begin
      case (st_r)
        LDSEQ_OFF: begin
          if (act) begin
            st_r  <= (pre_boost_delay == '0) ? LDSEQ_ON : LDSEQ_PRE;
            cnt_r <= PBD_W'(1);
          end
        end
        LDSEQ_PRE: begin
          if (!enable_in) begin
            st_r <= LDSEQ_OFF;
          end else if (cnt_r >= pbd_r) begin
            st_r <= LDSEQ_ON;
          end else begin
            cnt_r <= cnt_r + PBD_W'(1);
          end
        end
        LDSEQ_ON: begin
          if (!enable_in) begin
            st_r <= LDSEQ_OFF;
          end else if (!dim_pulse_in) begin
            st_r  <= (pbd_r == '0) ? LDSEQ_OFF : LDSEQ_TAIL;
            cnt_r <= PBD_W'(1);
          end
        end
        LDSEQ_TAIL: begin
          if (!enable_in) begin
            st_r <= LDSEQ_OFF;
          end else if (cnt_r >= pbd_r) begin
            st_r <= LDSEQ_OFF;
          end else begin
            cnt_r <= cnt_r + PBD_W'(1);
          end
        end
        default: st_r <= LDSEQ_OFF;
      endcase
    end
  end

  // ==========================================================
  // outputs; enable low cuts sinks at once, the tail follows only the pulse
  always_comb begin
    sink_r  = enable_in && (st_r == LDSEQ_ON || st_r == LDSEQ_TAIL);
    boost_r = enable_in && st_r != LDSEQ_OFF;
  end

  assign sink_on    = sink_r ? sink_enable : 4'h0;
  assign boost_on   = boost_r;
  assign comp_float = ~sink_r;
  assign bias_keep  = enable_in;

  // ==========================================================
  // analog dimming reference
  ldseq_duty u_duty (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .dim_in    (analog_dim_duty_input),
    .ref_level (current_set_reference)
  );

  // ==========================================================
  // checks
  sink_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !enable_in |-> sink_on == 4'h0 && !boost_on)
    else $error("sinks active with enable low");
  sink_need_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    sink_on != 4'h0 |-> enable_in)
    else $error("sinks on without enable");
  boost_first_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    st_r == LDSEQ_OFF && act |=> boost_on || !enable_in)
    else $error("boost not started on rise");
  pre_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    st_r == LDSEQ_PRE |-> sink_on == 4'h0 && comp_float)
    else $error("sinks on during pre-boost");
  tail_keep_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    st_r == LDSEQ_ON && enable_in && !dim_pulse_in && pbd_r != '0
    |=> boost_on || !enable_in)
    else $error("boost dropped before tail");
  pre_len_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    st_r == LDSEQ_PRE && cnt_r < pbd_r && enable_in |=> st_r == LDSEQ_PRE)
    else $error("pre-boost ended early");
  short_pulse_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(act) && st_r == LDSEQ_OFF |=> st_r != LDSEQ_OFF || !enable_in)
    else $error("short pulse lost");
  comp_float_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    comp_float == (sink_on == 4'h0 || sink_enable == 4'h0 ? comp_float : 1'b0))
    else $error("comp not driven while sinks on");

  // ==========================================================
  // checker helpers: cycles spent in each timed state, read by assertions only
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pre_age_r <= '0;
    end else if (st_r == LDSEQ_PRE) begin
      pre_age_r <= pre_age_r + PBD_W'(1);
    end else begin
      pre_age_r <= '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      tail_age_r <= '0;
    end else if (st_r == LDSEQ_TAIL) begin
      tail_age_r <= tail_age_r + PBD_W'(1);
    end else begin
      tail_age_r <= '0;
    end
  end

  // ==========================================================
  // sequencing checks; the interval is held constant between rises
  pre_age_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    st_r == LDSEQ_PRE |-> pre_age_r < pbd_r)
    else $error("pre-boost longer than interval");
  tail_age_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    st_r == LDSEQ_TAIL |-> tail_age_r < pbd_r)
    else $error("tail longer than interval");
  pre_end_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    st_r == LDSEQ_PRE && enable_in && cnt_r >= pbd_r |=> st_r == LDSEQ_ON)
    else $error("sinks not enabled after pre-boost");
  tail_len_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    st_r == LDSEQ_TAIL && enable_in && cnt_r < pbd_r |=> st_r == LDSEQ_TAIL)
    else $error("tail ended early");
  tail_end_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    st_r == LDSEQ_TAIL && enable_in && cnt_r >= pbd_r |=> st_r == LDSEQ_OFF)
    else $error("tail overran interval");
  on_fall_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    st_r == LDSEQ_ON && enable_in && !dim_pulse_in |=> st_r != LDSEQ_ON)
    else $error("pulse fall missed");
  drop_off_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    st_r != LDSEQ_OFF && !enable_in |=> st_r == LDSEQ_OFF)
    else $error("enable low did not stop sequence");
  off_quiet_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    st_r == LDSEQ_OFF |-> sink_on == 4'h0 && !boost_on)
    else $error("outputs active while off");
  sink_mask_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    sink_r |-> sink_on == sink_enable)
    else $error("enabled sinks not all on");
  bias_keep_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    enable_in |-> bias_keep)
    else $error("bias dropped while enabled");
  pbd_latch_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    st_r == LDSEQ_OFF && act |=> pbd_r == $past(pre_boost_delay))
    else $error("interval not latched at rise");
  state_hot_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $onehot(st_r))
    else $error("sequencer state not one-hot");

  cov_pre_c: cover property (@(posedge ref_clk) disable iff (!nrst)
    st_r == LDSEQ_PRE ##1 st_r == LDSEQ_ON);
  cov_tail_c: cover property (@(posedge ref_clk) disable iff (!nrst)
    st_r == LDSEQ_TAIL ##1 st_r == LDSEQ_OFF);
  cov_short_c: cover property (@(posedge ref_clk) disable iff (!nrst)
    $rose(act) ##2 !act);
endmodule

// ==== tb/ldseq_host.sv ====
// ldseq_host: host side model, makes the analog dim pulse train
// assumes period and high time are given in ref_clk cycles
`timescale 1ns/1ps
module ldseq_host (
  input  wire logic ref_clk,
  input  int        per,
  input  int        hi,
  output logic      duty_o
);
  int cnt = 0;
  initial duty_o = 1'b0;
  // ==========================================================
  // pulse train
  // zero period is idle: the pin rests at its pull-down level
  always @(posedge ref_clk) begin
    #1;
    cnt = (cnt + 1 >= per) ? 0 : cnt + 1;
    duty_o = (per > 0) && (cnt < hi);
  end
endmodule

// ==== tb/ldseq_top_tb_top.sv ====
// ldseq_top_tb_top: drives dimming pulses and duty trains, checks gates
// assumes ldseq_host drives the duty input; model notes expected gates
`timescale 1ns/1ps
module ldseq_top_tb_top;
  import ldseq_pkg::*;
  logic              ref_clk = 1'b0;
  logic              nrst    = 1'b0;
  logic              en      = 1'b0;
  logic              pls     = 1'b0;
  logic              duty;
  logic              on;
  logic [PBD_W-1:0]  dly     = 12'h000;
  logic [3:0]        snk_en  = 4'h0;
  logic [3:0]        sink_on;
  logic              boost_on;
  logic              comp_float;
  logic              bias_keep;
  logic [DUTY_W-1:0] cref;
  logic [31:0]       seed    = 32'hD42940A9;
  logic [6:0]        q[$];
  int                per     = 0;
  int                hi      = 0;
  int                n_fail  = 0;
  int                checked = 0;
  int                cnt     = 0;
  ldseq_state_t      st      = LDSEQ_OFF;
  always #2 ref_clk = ~ref_clk;
  ldseq_host host_u (.ref_clk(ref_clk), .per(per), .hi(hi), .duty_o(duty));
  ldseq_top dut_u (.ref_clk(ref_clk), .nrst(nrst), .enable_in(en), .dim_pulse_in(pls),
    .analog_dim_duty_input(duty), .pre_boost_delay(dly), .sink_enable(snk_en),
    .sink_on(sink_on), .boost_on(boost_on), .comp_float(comp_float),
    .bias_keep(bias_keep), .current_set_reference(cref));
  // ==========================================================
  // reference sequencer; notes land between input change and negedge
  always @(posedge ref_clk) begin
    if (!nrst || !en) begin
      st = LDSEQ_OFF;
    end else if (st == LDSEQ_OFF && pls) begin
      st = (dly == 0) ? LDSEQ_ON : LDSEQ_PRE;
      cnt = dly;
    end else if (st == LDSEQ_ON && !pls) begin
      st = (dly == 0) ? LDSEQ_OFF : LDSEQ_TAIL;
      cnt = dly;
    end else if (st == LDSEQ_PRE || st == LDSEQ_TAIL) begin
      if (cnt <= 1) st = (st == LDSEQ_PRE) ? LDSEQ_ON : LDSEQ_OFF;
      else cnt--;
    end
    #1.5;
    on = en && (st == LDSEQ_ON || st == LDSEQ_TAIL);
    q.push_back({on ? snk_en : 4'h0, en && st != LDSEQ_OFF, !on, en});
  end
  always @(negedge ref_clk) begin
    if (q.size() > 0) cmp_gate(q.pop_front());
  end
  // ==========================================================
  // tasks
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic cmp_gate(input logic [6:0] e);
    checked++;
    if ({sink_on, boost_on, comp_float, bias_keep} !== e) begin
      n_fail++;
      $display("unexpected gates exp %h seen %h", e,
               {sink_on, boost_on, comp_float, bias_keep});
    end
  endtask
  // filter truncation may stall short of the ideal level, hence a band
  task automatic cmp_ref(input int lo, input int up);
    checked++;
    if ($isunknown(cref) || cref < lo || cref > up) begin
      n_fail++;
      $display("unexpected reference exp %0d..%0d seen %h", lo, up, cref);
    end
  endtask
  task automatic pulse(input int w, input int g);
    pls = 1'b1;
    tick(w);
    pls = 1'b0;
    tick(g);
  endtask
  task automatic report_and_stop();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    tick(20);
    nrst = 1'b1;
    tick(2);
    cmp_ref(255, 255);
    en = 1'b1;
    for (int i = 0; i < 12; i++) begin
      dly = (i == 0) ? 12'h000 : 12'(rnd() % 16);
      snk_en = 4'(rnd() % 15 + 1);
      pulse(MIN_ON_CYC + rnd() % 8, rnd() % 8 + 1);
      pulse(MIN_ON_CYC, 20);
    end
    pls = 1'b1;
    tick(40);
    en = 1'b0;
    tick(5);
    pls = 1'b0;
    en = 1'b1;
    tick(20);
    per = 250;
    hi = 50;
    tick(25000);
    cmp_ref(188, 220);
    hi = 240;
    tick(25000);
    cmp_ref(0, 26);
    per = 0;
    tick(8000);
    cmp_ref(240, 255);
    report_and_stop();
  end
endmodule
